// ### logic/rfl_defs.svh
// Constants of the result FIFO, flag and limit block: command codes,
// field positions, reset values and sizes.
// Assumes inclusion by bare name from the package and the core module.
`ifndef RFL_DEFS_SVH
`define RFL_DEFS_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define RFL_FIFO_DEPTH 32
`define RFL_PTR_W 5
`define RFL_CNT_W 6
`define RFL_RES_W 24
`define RFL_FULL_COUNT 6'h20
`define RFL_OVR_COUNT 6'h1F

// ----------------------------------------------------------------------
// Operation register fields and reset value
// ----------------------------------------------------------------------
`define RFL_OP_RESET 16'h0000
`define RFL_OP_THR_HI 12
`define RFL_OP_THR_LO 8
`define RFL_OP_MODE_HI 7
`define RFL_OP_MODE_LO 6
`define RFL_OP_DELAY_HI 3
`define RFL_OP_DELAY_LO 0

// ----------------------------------------------------------------------
// Flag bit positions and reset values
// ----------------------------------------------------------------------
`define RFL_FLG_CRC 7
`define RFL_FLG_PHI 6
`define RFL_FLG_PLO 5
`define RFL_FLG_THI 4
`define RFL_FLG_TLO 3
`define RFL_FLG_FULL 2
`define RFL_FLG_THR 1
`define RFL_FLG_DONE 0
`define RFL_FLAGS_RESET 8'h00
`define RFL_MASK_RESET 8'h00

// ----------------------------------------------------------------------
// Limit indices and reset values
// ----------------------------------------------------------------------
`define RFL_LIM_TFLOOR 2'h0
`define RFL_LIM_TCEIL 2'h1
`define RFL_LIM_PFLOOR 2'h2
`define RFL_LIM_PCEIL 2'h3
`define RFL_FLOOR_RESET 16'h0000
`define RFL_CEIL_RESET 16'hFFFF

// ----------------------------------------------------------------------
// Command codes (upper seven bits unless noted)
// ----------------------------------------------------------------------
`define RFL_CMD_OP_WR 7'h0A
`define RFL_CMD_OP_RD 7'h0B
`define RFL_CMD_MASK_WR 7'h0C
`define RFL_CMD_MASK_RD 7'h0D
`define RFL_CMD_FLAG_WR 7'h0E
`define RFL_CMD_FLAG_RD 7'h0F
`define RFL_CMD_CFG_WR 6'h08
`define RFL_CMD_LIM_WR 5'h06
`define RFL_CMD_LIM_RD 5'h07
`define RFL_CMD_ADC_RD 4'h5

`endif

// ### logic/rfl_pkg.sv
// Types shared by the result FIFO, flag and limit block.
// Assumes rfl_defs.svh is on the include path.
`include "rfl_defs.svh"

package rfl_pkg;
   // Buffer mode field of the operation register
   typedef enum logic [1:0] {
      RFL_MODE_OFF = 2'b00,
      RFL_MODE_STOP = 2'b01,
      RFL_MODE_OVR = 2'b10,
      RFL_MODE_OVR_ALT = 2'b11
   } rfl_mode_t;

   typedef logic [7:0] rfl_byte_t;
   typedef logic [15:0] rfl_word_t;
   typedef logic [`RFL_RES_W-1:0] rfl_result_t;
   typedef logic [2*`RFL_RES_W-1:0] rfl_pair_t;
   typedef logic [`RFL_PTR_W-1:0] rfl_ptr_t;
   typedef logic [`RFL_CNT_W-1:0] rfl_count_t;
endpackage

// ### logic/rfl_core.sv
// Result FIFO, event flags, mask and raw limit checks of the sensor core.
// Assumes a serial front end on linkClk that hands over whole command
// bytes, and a converter on ref_clk that reports finished results.
//
// Behaviour
// - Buffer 32 pairs, read back in order
// - Operation bits 7:6 choose buffer mode
// - Mode 0 off, 1 stop, 2/3 overwrite
// - Stop mode drops pairs once 32 held
// - Overwrite mode replaces oldest slot cyclically
// - Single and automatic conversions both store
// - Read sends entry, pointer advances at start
// - Overwrite mode keeps at most 31 entries
// - Threshold flag when n entries held
// - Threshold zero never raises threshold flag
// - Buffer flags update only at conversion end
// - Mode off empties buffer, resets pointers
// - Configuration writes refused during automatic mode
// - Pair carries latest temperature with new pressure
// - Ticks without conversion store no entry
// - Pin only for enabled flags, mask resets zero
// - Flags clear by writing one, zero keeps
// - Flag bit order: crc down to done
// - Full, done and checksum flags set
// - Flags rise as soon as result exists
// - Done flag rises again after pressure
// - Four 16-bit limits with fixed reset values
// - Compare upper 16 bits of filtered result
// - Compare once at conversion end only
// - Limit commands 00110/00111 with two-bit index
// - Mask and flag command codes, bit 0 ignored
// - Commands are single bytes on either link
`timescale 1ns/1ps
`default_nettype none
`include "rfl_defs.svh"

module rfl_core (
   // Core clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Link side, on the serial clock
   input wire logic linkClk,
   input wire logic cmdValid,
   input wire rfl_pkg::rfl_byte_t cmdByte,
   input wire rfl_pkg::rfl_word_t cmdData,
   output logic rspValid,
   output rfl_pkg::rfl_pair_t rspData,
   // Converter results
   input wire logic tDone,
   input wire rfl_pkg::rfl_result_t tResult,
   input wire logic pDone,
   input wire rfl_pkg::rfl_result_t pResult,
   input wire logic setDone,
   input wire logic crcFail,
   // Configuration and automatic mode
   output logic cfgWrite,
   output logic cfgWriteSel,
   output rfl_pkg::rfl_word_t cfgWriteData,
   output logic autoRun,
   // Interrupt pin
   output logic intPin
);
   import rfl_pkg::*;

   // -------------------------------------------------------------------
   // Link domain: command capture and answer delivery
   // -------------------------------------------------------------------
   logic linkRstMeta;
   logic linkRst;
   rfl_byte_t cmdHold;
   rfl_word_t dataHold;
   logic reqTgl;
   logic rspTgl;
   rfl_pair_t rspHold;
   logic rspMeta;
   logic rspSync;
   logic rspSeen;

   // Reset carried into the link clock before any link logic uses it
   always_ff @(posedge linkClk) begin
      linkRstMeta <= rst;
      linkRst <= linkRstMeta;
   end

   // One byte per command, held until the core has taken it
   always_ff @(posedge linkClk) begin
      if (linkRst) begin
         cmdHold <= 8'h00;
         dataHold <= 16'h0000;
         reqTgl <= 1'b0;
      end else if (cmdValid) begin
         cmdHold <= cmdByte;
         dataHold <= cmdData;
         reqTgl <= ~reqTgl;
      end
   end

   // Answer toggle synchronised; data is stable before the toggle moves
   always_ff @(posedge linkClk) begin
      if (linkRst) begin
         rspMeta <= 1'b0;
         rspSync <= 1'b0;
         rspSeen <= 1'b0;
         rspValid <= 1'b0;
         rspData <= 48'h000000000000;
      end else begin
         rspMeta <= rspTgl;
         rspSync <= rspMeta;
         rspSeen <= rspSync;
         rspValid <= rspSync ^ rspSeen;
         if (rspSync ^ rspSeen) begin
            rspData <= rspHold;
         end
      end
   end

   // -------------------------------------------------------------------
   // Core domain: command decode
   // -------------------------------------------------------------------
   logic reqMeta;
   logic reqSync;
   logic reqSeen;
   logic cmdTake;
   logic [6:0] cmdOp;
   logic [1:0] limIdx;

   // Request toggle through two flops, then edge found on later stages
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reqMeta <= 1'b0;
         reqSync <= 1'b0;
         reqSeen <= 1'b0;
      end else begin
         reqMeta <= reqTgl;
         reqSync <= reqMeta;
         reqSeen <= reqSync;
      end
   end

   assign cmdTake = reqSync ^ reqSeen;
   assign cmdOp = cmdHold[7:1];
   assign limIdx = cmdHold[2:1];

   logic opWr;
   logic opRd;
   logic maskWr;
   logic maskRd;
   logic flagWr;
   logic flagRd;
   logic limWr;
   logic limRd;
   logic adcRd;
   logic cfgWr;

   // Bit 0 of every byte is a don't-care
   always_comb begin
      opWr = cmdTake && (cmdOp == `RFL_CMD_OP_WR);
      opRd = cmdTake && (cmdOp == `RFL_CMD_OP_RD);
      maskWr = cmdTake && (cmdOp == `RFL_CMD_MASK_WR);
      maskRd = cmdTake && (cmdOp == `RFL_CMD_MASK_RD);
      flagWr = cmdTake && (cmdOp == `RFL_CMD_FLAG_WR);
      flagRd = cmdTake && (cmdOp == `RFL_CMD_FLAG_RD);
      limWr = cmdTake && (cmdHold[7:3] == `RFL_CMD_LIM_WR);
      limRd = cmdTake && (cmdHold[7:3] == `RFL_CMD_LIM_RD);
      adcRd = cmdTake && (cmdHold[7:4] == `RFL_CMD_ADC_RD);
      cfgWr = cmdTake && (cmdHold[7:2] == `RFL_CMD_CFG_WR);
   end

   // -------------------------------------------------------------------
   // Operation register and configuration gate
   // -------------------------------------------------------------------
   rfl_word_t opReg;
   rfl_mode_t mode;
   logic [4:0] thr;

   assign mode = rfl_mode_t'(opReg[`RFL_OP_MODE_HI:`RFL_OP_MODE_LO]);
   assign thr = opReg[`RFL_OP_THR_HI:`RFL_OP_THR_LO];

   // Operation register; a nonzero delay means automatic mode runs
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         opReg <= `RFL_OP_RESET;
         autoRun <= 1'b0;
      end else begin
         if (opWr) begin
            opReg <= dataHold;
         end
         autoRun <= (opReg[`RFL_OP_DELAY_HI:`RFL_OP_DELAY_LO] != 4'h0);
      end
   end

   // Config writes pass on only while automatic mode is idle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cfgWrite <= 1'b0;
         cfgWriteSel <= 1'b0;
         cfgWriteData <= 16'h0000;
      end else begin
         cfgWrite <= cfgWr && !autoRun;
         // A refused write leaves the last accepted one visible
         if (cfgWr && !autoRun) begin
            cfgWriteSel <= cmdHold[1];
            cfgWriteData <= dataHold;
         end
      end
   end

   // -------------------------------------------------------------------
   // Latest results and limit registers
   // -------------------------------------------------------------------
   rfl_result_t lastT;
   rfl_result_t lastP;
   rfl_word_t limits [4];

   // Pairs reuse the newest temperature when pressure runs faster
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lastT <= 24'h000000;
         lastP <= 24'h000000;
      end else begin
         if (tDone) begin
            lastT <= tResult;
         end
         if (pDone) begin
            lastP <= pResult;
         end
      end
   end

   // Limit registers; new values affect only later conversions
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         limits[`RFL_LIM_TFLOOR] <= `RFL_FLOOR_RESET;
         limits[`RFL_LIM_TCEIL] <= `RFL_CEIL_RESET;
         limits[`RFL_LIM_PFLOOR] <= `RFL_FLOOR_RESET;
         limits[`RFL_LIM_PCEIL] <= `RFL_CEIL_RESET;
      end else if (limWr) begin
         limits[limIdx] <= dataHold;
      end
   end

   // -------------------------------------------------------------------
   // Result FIFO
   // -------------------------------------------------------------------
   rfl_pair_t fifoMem [`RFL_FIFO_DEPTH];
   rfl_ptr_t wrPtr;
   rfl_ptr_t rdPtr;
   rfl_count_t count;
   logic fifoOn;
   logic store;
   logic dropOld;
   logic popOk;
   rfl_count_t next_count;

   assign fifoOn = (mode != RFL_MODE_OFF);

   // Store on every finished set unless the mode is off or stop mode holds 32, whatever started it
   always_comb begin
      popOk = adcRd && fifoOn && (count != 6'h00);
      store = 1'b0;
      dropOld = 1'b0;
      unique case (mode)
         RFL_MODE_OFF: store = 1'b0;
         RFL_MODE_STOP: store = setDone && (count != `RFL_FULL_COUNT);
         RFL_MODE_OVR, RFL_MODE_OVR_ALT: begin
            store = setDone;
            // A read in the same cycle already frees the oldest slot
            dropOld = setDone && (count == `RFL_OVR_COUNT) && !popOk;
         end
      endcase
      next_count = count;
      if (store && !dropOld && !popOk) begin
         next_count = count + 6'h01;
      end else if (popOk && !(store && !dropOld)) begin
         next_count = count - 6'h01;
      end
   end

   // Storage array; overwriting never touches the slot being read
   always_ff @(posedge ref_clk) begin
      if (store) begin
         fifoMem[wrPtr] <= {lastP, lastT};
      end
   end

   // Cursors; switching the mode off empties the buffer
   always_ff @(posedge ref_clk) begin
      if (rst || !fifoOn) begin
         wrPtr <= 5'h00;
         rdPtr <= 5'h00;
         count <= 6'h00;
      end else begin
         if (store) begin
            wrPtr <= wrPtr + 5'h01;
         end
         // An overwrite pushes the oldest out just like a read
         if (popOk || (dropOld && !popOk)) begin
            rdPtr <= rdPtr + 5'h01;
         end
         count <= next_count;
      end
   end

   // -------------------------------------------------------------------
   // Event flags and mask
   // -------------------------------------------------------------------
   rfl_byte_t flags;
   rfl_byte_t mask;
   rfl_byte_t setBits;
   rfl_byte_t clrBits;
   rfl_byte_t next_flags;
   rfl_count_t storedCount;

   // Count as it stands after this cycle's store, for buffer flags
   assign storedCount = next_count;

   // Each flag rises on the cycle its own result arrives
   always_comb begin
      setBits = 8'h00;
      setBits[`RFL_FLG_CRC] = crcFail;
      // Upper 16 bits of the filtered result against the held limit
      setBits[`RFL_FLG_THI] = tDone && (tResult[23:8] > limits[`RFL_LIM_TCEIL]);
      setBits[`RFL_FLG_TLO] = tDone && (tResult[23:8] < limits[`RFL_LIM_TFLOOR]);
      setBits[`RFL_FLG_PHI] = pDone && (pResult[23:8] > limits[`RFL_LIM_PCEIL]);
      setBits[`RFL_FLG_PLO] = pDone && (pResult[23:8] < limits[`RFL_LIM_PFLOOR]);
      setBits[`RFL_FLG_DONE] = tDone || pDone;
      // Buffer flags only move when a set of conversions lands
      setBits[`RFL_FLG_FULL] = store && (storedCount == `RFL_FULL_COUNT);
      setBits[`RFL_FLG_THR] = store && (thr != 5'h00)
         && (storedCount >= {1'b0, thr});
      clrBits = flagWr ? dataHold[7:0] : 8'h00;
      // A new event beats a clear landing in the same cycle
      next_flags = (flags & ~clrBits) | setBits;
   end

   // Flag and mask registers, bit order as laid out in the defines
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         flags <= `RFL_FLAGS_RESET;
         mask <= `RFL_MASK_RESET;
      end else begin
         flags <= next_flags;
         if (maskWr) begin
            mask <= dataHold[7:0];
         end
      end
   end

   // Pin follows the masked flags one cycle later
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         intPin <= 1'b0;
      end else begin
         intPin <= |(flags & mask);
      end
   end

   // -------------------------------------------------------------------
   // Read answers back to the link
   // -------------------------------------------------------------------
   logic anyRd;
   rfl_pair_t rdWord;

   assign anyRd = opRd || maskRd || flagRd || limRd || adcRd;

   // Answer word, narrower registers zero-extended in the low bits
   always_comb begin
      rdWord = 48'h000000000000;
      if (opRd) begin
         rdWord[15:0] = opReg;
      end else if (maskRd) begin
         rdWord[7:0] = mask;
      end else if (flagRd) begin
         rdWord[7:0] = flags;
      end else if (limRd) begin
         rdWord[15:0] = limits[limIdx];
      end else if (popOk) begin
         rdWord = fifoMem[rdPtr];
      end else if (adcRd && !fifoOn) begin
         rdWord = {lastP, lastT};
      end
   end

   // Hold the answer, then flip the toggle so the link can take it
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rspHold <= 48'h000000000000;
         rspTgl <= 1'b0;
      end else if (anyRd) begin
         rspHold <= rdWord;
         rspTgl <= ~rspTgl;
      end
   end

endmodule
`default_nettype wire

// ### verif/rfl_core_monitor.sv
// Port timing checks for rfl_core.
// Assumes it is bound to every rfl_core instance.
`timescale 1ns/1ps
`default_nettype none
module rfl_core_chk (
   // Clocks and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic linkClk,
   // Link side
   input wire logic cmdValid,
   input wire rfl_pkg::rfl_byte_t cmdByte,
   input wire logic rspValid,
   input wire rfl_pkg::rfl_pair_t rspData,
   // Core side
   input wire logic cfgWrite,
   input wire logic autoRun,
   input wire logic intPin
);
   import rfl_pkg::*;
   logic isRd;
   // Read codes; bit 0 is a don't-care
   assign isRd = cmdByte[7:1] inside {7'h0B, 7'h0D, 7'h0F} || cmdByte[7:3] == 5'h07
      || cmdByte[7:4] == 4'h5;
   sequence s_rd_req;
      cmdValid && isRd;
   endsequence
   sequence s_wr_req;
      cmdValid && !isRd;
   endsequence
   // Answers come after two crossings, so allow a window
   chk_rd_answered: assert property (@(posedge linkClk) disable iff (rst)
      s_rd_req |-> ##[4:12] rspValid) else $error("read got no answer");
   chk_wr_silent: assert property (@(posedge linkClk) disable iff (rst)
      s_wr_req |=> !rspValid [*8]) else $error("write produced an answer");
   chk_rsp_pulse: assert property (@(posedge linkClk) disable iff (rst)
      rspValid |=> !rspValid) else $error("answer strobe too long");
   chk_rsp_hold: assert property (@(posedge linkClk) disable iff (rst)
      $changed(rspData) |-> rspValid) else $error("answer data moved alone");
   chk_cfg_pulse: assert property (@(posedge ref_clk) disable iff (rst)
      cfgWrite |=> !cfgWrite) else $error("config strobe too long");
   chk_cfg_refused: assert property (@(posedge ref_clk) disable iff (rst)
      autoRun [*4] |-> !cfgWrite) else $error("config taken in automatic mode");
   // Reset itself is the antecedent, so no disable here
   chk_core_reset: assert property (@(posedge ref_clk)
      rst ##1 rst ##1 rst |-> !intPin && !autoRun && !cfgWrite)
      else $error("core outputs not cleared by reset");
   chk_link_reset: assert property (@(posedge linkClk)
      rst [*4] |-> !rspValid && rspData == '0) else $error("link outputs not cleared");
endmodule
bind rfl_core rfl_core_chk chk_u (.ref_clk(ref_clk), .rst(rst), .linkClk(linkClk),
   .cmdValid(cmdValid), .cmdByte(cmdByte), .rspValid(rspValid), .rspData(rspData),
   .cfgWrite(cfgWrite), .autoRun(autoRun), .intPin(intPin));
`default_nettype wire

// ### verif/rfl_host_model.sv
// Host model: issues one command at a time on the link clock.
// Assumes the bench serialises calls to send.
`timescale 1ns/1ps
`default_nettype none
module rfl_host_model (
   // Link clock and answer strobe
   input wire logic linkClk,
   input wire logic rspValid,
   // Command lines
   output logic cmdValid,
   output rfl_pkg::rfl_byte_t cmdByte,
   output rfl_pkg::rfl_word_t cmdData
);
   import rfl_pkg::*;
   initial begin
      cmdValid = 1'b0;
      cmdByte = 8'h00;
      cmdData = 16'h0000;
   end
   // One whole byte per command, then wait out the answer or gap
   task automatic send(input rfl_byte_t b, input rfl_word_t d, input bit rd,
                       output bit ok);
      int n;
      @(negedge linkClk);
      cmdValid = 1'b1;
      cmdByte = b;
      cmdData = d;
      @(negedge linkClk);
      cmdValid = 1'b0;
      // Idle lines show junk so a stale value cannot pass
      cmdByte = ~b;
      cmdData = ~d;
      ok = !rd;
      for (n = 0; n < 20 && !ok; n++) begin
         @(negedge linkClk);
         ok = (rspValid === 1'b1);
      end
      if (!rd)
         repeat (10) @(negedge linkClk);
   endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Bench for rfl_core: host model on the link, converter pulses here.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rfl_pkg::*;
   logic ref_clk = 1'b0;
   logic linkClk = 1'b0;
   logic rst = 1'b1;
   logic tDone = 1'b0, pDone = 1'b0, setDone = 1'b0, crcFail = 1'b0;
   logic cmdValid, rspValid, cfgWrite, cfgWriteSel, autoRun, intPin;
   rfl_byte_t cmdByte;
   rfl_word_t cmdData, cfgWriteData;
   rfl_pair_t rspData;
   rfl_result_t tResult = 24'h000000, pResult = 24'h000000;
   int fail_count = 0, n_compared = 0, cfgCount = 0;
   int seed = 32'h4DC5775A;
   rfl_pair_t expQ[$], fifo[$];

   always #20 ref_clk = ~ref_clk;
   // Period 48 against 40, so crossings step through five phases
   always #24 linkClk = ~linkClk;

   rfl_core dut_u (.ref_clk(ref_clk), .rst(rst), .linkClk(linkClk), .cmdValid(cmdValid),
      .cmdByte(cmdByte), .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData),
      .tDone(tDone), .tResult(tResult), .pDone(pDone), .pResult(pResult),
      .setDone(setDone), .crcFail(crcFail), .cfgWrite(cfgWrite),
      .cfgWriteSel(cfgWriteSel), .cfgWriteData(cfgWriteData), .autoRun(autoRun),
      .intPin(intPin));
   rfl_host_model host_u (.linkClk(linkClk), .rspValid(rspValid), .cmdValid(cmdValid),
      .cmdByte(cmdByte), .cmdData(cmdData));

   task automatic cmp(input rfl_pair_t e, input rfl_pair_t a);
      n_compared++;
      if (a !== e) begin
         fail_count++;
         $display("[ERR] %0t exp %h got %h", $time, e, a);
      end
   endtask

   task automatic final_report;
      if (fail_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Oldest note is matched against each answer; a stray answer fails
   always @(negedge linkClk) begin
      if (rspValid === 1'b1)
         cmp(expQ.size() ? expQ.pop_front() : ~rspData, rspData);
   end

   // Counted off the falling edge, half a cycle after the rising edge launches the strobe
   always @(negedge ref_clk) begin
      if (cfgWrite === 1'b1)
         cfgCount++;
   end

   task automatic wr(input rfl_byte_t b, input rfl_word_t d);
      bit ok;
      host_u.send(b, d, 1'b0, ok);
   endtask

   task automatic rd(input rfl_byte_t b, input rfl_pair_t e);
      bit ok;
      expQ.push_back(e);
      host_u.send(b, 16'h0000, 1'b1, ok);
      if (!ok) begin
         fail_count++;
         final_report();
      end
   endtask

   // Temperature, then pressure, then optional store of the pair
   task automatic conv(input rfl_result_t t, input rfl_result_t p, input bit st);
      @(negedge ref_clk);
      tDone = 1'b1;
      tResult = t;
      @(negedge ref_clk);
      tDone = 1'b0;
      pDone = 1'b1;
      pResult = p;
      @(negedge ref_clk);
      pDone = 1'b0;
      setDone = st;
      @(negedge ref_clk);
      setDone = 1'b0;
   endtask

   initial begin
      int i, m, n;
      rfl_result_t t, p;
      repeat (10) @(negedge ref_clk);
      rst = 1'b0;
      repeat (4) @(negedge linkClk);
      // Reset values, then a random round trip per limit
      for (i = 0; i < 4; i++)
         rd({5'h07, i[1:0], 1'b0}, {32'h0, {16{i[0]}}});
      rd(8'h1A, 48'h0);
      rd(8'h1E, 48'h0);
      for (i = 0; i < 4; i++) begin
         n = $random(seed);
         wr({5'h06, i[1:0], 1'b1}, n[15:0]);
         rd({5'h07, i[1:0], 1'b0}, {32'h0, n[15:0]});
      end
      wr(8'h30, 16'h0000);
      wr(8'h32, 16'h8000);
      wr(8'h34, 16'h1000);
      wr(8'h36, 16'hFFFF);
      wr(8'h1C, 16'h00FF);
      // Equal to a limit is inside; one step past is outside
      conv(24'h8000FF, 24'h100000, 1'b0);
      rd(8'h1E, 48'h01);
      conv(24'h800100, 24'h0FFFFF, 1'b0);
      rd(8'h1E, 48'h31);
      @(negedge ref_clk);
      crcFail = 1'b1;
      @(negedge ref_clk);
      crcFail = 1'b0;
      rd(8'h1F, 48'hB1);
      wr(8'h18, 16'h0080);
      cmp(48'h1, {47'h0, intPin});
      wr(8'h1C, 16'h0021);
      rd(8'h1E, 48'h90);
      wr(8'h19, 16'h0001);
      cmp(48'h0, {47'h0, intPin});
      rd(8'h1B, 48'h01);
      // Config write taken while idle, refused in automatic mode
      n = cfgCount;
      wr(8'h22, 16'h5A3C);
      cmp(48'h5A3C, {32'h0, cfgWriteData});
      cmp(48'h1, {47'h0, cfgWriteSel});
      wr(8'h14, 16'h0001);
      cmp(48'h1, {47'h0, autoRun});
      wr(8'h20, 16'h1111);
      cmp(48'(n + 1), 48'(cfgCount));
      // The refused write must leave the accepted one in place
      cmp(48'h5A3C, {32'h0, cfgWriteData});
      cmp(48'h1, {47'h0, cfgWriteSel});
      wr(8'h14, 16'h0000);
      wr(8'h32, 16'hFFFF);
      wr(8'h34, 16'h0000);
      // Overfill in stop, overwrite and zero-threshold overwrite modes
      for (m = 1; m < 4; m++) begin
         wr(8'h14, {3'h0, (m == 3) ? 5'h00 : 5'h05, m[1:0], 6'h00});
         wr(8'h1C, 16'h00FF);
         for (i = 0; i < 33; i++) begin
            t = 24'($random(seed));
            p = 24'($random(seed));
            conv(t, p, 1'b1);
            fifo.push_back({p, t});
            if (m == 1 && fifo.size() > 32)
               void'(fifo.pop_back());
            if (m != 1 && fifo.size() > 31)
               void'(fifo.pop_front());
         end
         rd(8'h1E, {40'h0, 5'h00, m == 1, m != 3, 1'b1});
         n = fifo.size();
         for (i = 0; i < n; i++)
            rd(8'h50, fifo.pop_front());
         rd(8'h50, 48'h0);
         wr(8'h14, 16'h0000);
      end
      // Switching the mode off must discard held pairs
      wr(8'h14, 16'h0040);
      conv(24'h123456, 24'h654321, 1'b1);
      wr(8'h14, 16'h0000);
      wr(8'h14, 16'h0040);
      rd(8'h50, 48'h0);
      // With the buffer off a read returns the newest pair
      wr(8'h14, 16'h0000);
      rd(8'h50, {24'h654321, 24'h123456});
      final_report();
   end
endmodule
`default_nettype wire
